// *** design/eind_top.sv ***
// External interrupt pin and NMI detection with APB register access.
// Assumes pins are asynchronous to pclk; stop_mode comes from pclk logic.
`timescale 1ns/1ps
`include "eind_consts.svh"

// Functional notes
// R1 - Two-bit selector per pin, sixteen pins filling one 32-bit register
// R2 - Selector codes: 00 low, 01 high, 10 rising, 11 falling
// R3 - Software leaves selectors of absent pins at zero
// R4 - Selected condition seen on a pin sets that pin's factor
// R5 - Read-only NMI flag at bit 0, resets 0, writes ignored
// R6 - NMI register bits 15:1 reserved, writes ignored
// R7 - Writing 0 to NMI clear bit clears factor; 1 does nothing
// R8 - NMI clear bit resets to 1 and always reads 1
// R9 - Inputs must last three clock cycles for reliable detection
// R10 - Level detection re-sets factor after clear while level persists
// R11 - NMI factor raised on falling edge of internal NMI signal
// R12 - In stop mode a low NMI level wakes the device
// R13 - NMI cannot be masked; a held factor always requests
// R14 - Port assigned away from NMI forces internal NMI high
// R15 - Reassigning port to NMI while input low raises NMI
// R16 - Software holds NMI input high while changing port assignment
// R17 - Software clears stale factors after changing detection selection
// R18 - Factors held regardless of enable; request only when enabled
// R19 - Writing 0 to factor clear bit clears it; reads return 1
// R20 - Read-only factor flag per pin set on detection
// R21 - Pins pass two synchroniser flops before detection
module eind_top #(
    parameter int NUM_PINS = 16
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire eind_pkg::eind_apb_req_t apb_req,
    output      eind_pkg::eind_apb_rsp_t apb_rsp,
    input  wire logic [NUM_PINS-1:0]    external_irq_pin,
    input  wire logic                   nonmaskable_input_pin,
    input  wire logic                   stop_mode,
    output      logic [NUM_PINS-1:0]    ext_irq_req,
    output      logic                   nmi_req,
    output      logic                   stop_wake
);

    // ======================================================================
    // Parameter check
    generate
        if (NUM_PINS < 1 || NUM_PINS > 16) begin : g_bad_pins
            $error("NUM_PINS must be 1 to 16");
        end
        if (`EIND_SYNC_STAGES != 2) begin : g_bad_sync
            $error("Synchroniser depth is fixed at two stages");
        end
    endgenerate

    localparam int SEL_W = 2 * NUM_PINS;
    localparam logic [NUM_PINS-1:0] PIN_IDLE = '1;
    localparam logic                NMI_IDLE = 1'b1;

    // ======================================================================
    // Declarations
    logic [NUM_PINS-1:0]      pin_meta;
    logic [NUM_PINS-1:0]      pin_sync;
    logic [NUM_PINS-1:0]      pin_prev;
    logic                     nmi_meta;
    logic                     nmi_sync;
    logic                     nmi_int;
    logic                     nmi_int_prev;
    logic [SEL_W-1:0]         detect_sel;
    logic [SEL_W-1:0]         next_detect_sel;
    logic [NUM_PINS-1:0]      enable_mask;
    logic [NUM_PINS-1:0]      next_enable_mask;
    logic                     port_function_select_bit;
    logic                     next_port_function_select_bit;
    logic [NUM_PINS-1:0]      factor_flags;
    logic [NUM_PINS-1:0]      next_factor_flags;
    logic                     nmi_detected_flag;
    logic                     next_nmi_detected_flag;
    logic [NUM_PINS-1:0]      pin_hit;
    logic [NUM_PINS-1:0]      clear_mask;
    logic                     nmi_hit;
    logic                     nmi_clear;
    logic [NUM_PINS-1:0]      next_ext_irq_req;
    logic                     next_nmi_req;
    logic                     next_stop_wake;
    eind_pkg::eind_bus_state_t bus_state;
    eind_pkg::eind_bus_state_t next_bus_state;
    logic [31:0]              next_prdata;
    logic                     next_pslverr;
    logic                     next_pready;
    logic [31:0]              rd_value;
    logic                     addr_hit;
    logic                     wr_go;
    logic [NUM_PINS-1:0]      next_pin_meta;
    logic [NUM_PINS-1:0]      next_pin_sync;
    logic [NUM_PINS-1:0]      next_pin_prev;
    logic                     next_nmi_meta;
    logic                     next_nmi_sync;
    logic                     next_nmi_int_prev;

    // ======================================================================
    // Pin synchronisers
    always_comb begin
        next_pin_meta     = external_irq_pin;       // R21
        next_pin_sync     = pin_meta;               // R21
        next_pin_prev     = pin_sync;               // R9
        next_nmi_meta     = nonmaskable_input_pin;  // R21
        next_nmi_sync     = nmi_meta;               // R21
        next_nmi_int_prev = nmi_int;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta     <= PIN_IDLE;
            pin_sync     <= PIN_IDLE;
            pin_prev     <= PIN_IDLE;
            nmi_meta     <= NMI_IDLE;
            nmi_sync     <= NMI_IDLE;
            nmi_int_prev <= NMI_IDLE;
        end else begin
            pin_meta     <= next_pin_meta;
            pin_sync     <= next_pin_sync;
            pin_prev     <= next_pin_prev;
            nmi_meta     <= next_nmi_meta;
            nmi_sync     <= next_nmi_sync;
            nmi_int_prev <= next_nmi_int_prev;
        end
    end

    // ======================================================================
    // Internal NMI signal
    always_comb begin
        nmi_int = port_function_select_bit ? 1'b1 : nmi_sync;  // R14
    end

    // ======================================================================
    // Per-pin condition detection
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            logic [1:0] sel;
            always_comb begin
                sel = {detect_sel[2*gi+1], detect_sel[2*gi]};  // R1
                case (sel)
                    `EIND_SEL_LOW:  pin_hit[gi] = ~pin_sync[gi];  // R2
                    `EIND_SEL_HIGH: pin_hit[gi] = pin_sync[gi];   // R2
                    `EIND_SEL_RISE:
                        pin_hit[gi] = pin_sync[gi] & ~pin_prev[gi];  // R2
                    default:
                        pin_hit[gi] = ~pin_sync[gi] & pin_prev[gi];  // R2
                endcase
            end
        end
    endgenerate

    // ======================================================================
    // NMI detection: falling edge normally, low level in stop mode
    always_comb begin
        nmi_hit = ~nmi_int & nmi_int_prev;  // R11 R15
        if (stop_mode && !nmi_int) begin
            nmi_hit = 1'b1;  // R12
        end
    end

    // ======================================================================
    // Bus decode
    always_comb begin
        addr_hit = 1'b1;
        rd_value = `EIND_ZERO;
        if (apb_req.paddr == `EIND_OFF_SEL) begin
            rd_value[SEL_W-1:0] = detect_sel;
        end else if (apb_req.paddr == `EIND_OFF_FLAGS) begin
            rd_value[NUM_PINS-1:0] = factor_flags;  // R20
        end else if (apb_req.paddr == `EIND_OFF_FCLR) begin
            rd_value[NUM_PINS-1:0] = '1;  // R19
        end else if (apb_req.paddr == `EIND_OFF_ENA) begin
            rd_value[NUM_PINS-1:0] = enable_mask;
        end else if (apb_req.paddr == `EIND_OFF_NMI_STS) begin
            rd_value[`EIND_NMI_BIT] = nmi_detected_flag;  // R5 R6
        end else if (apb_req.paddr == `EIND_OFF_NMI_CLR) begin
            rd_value = `EIND_NMI_CLR_RD;  // R8 R6
        end else if (apb_req.paddr == `EIND_OFF_PORTSEL) begin
            rd_value[`EIND_PFS_BIT] = port_function_select_bit;
        end else begin
            addr_hit = 1'b0;
        end
        wr_go = apb_req.psel & apb_req.penable & apb_req.pwrite
              & (bus_state == eind_pkg::EIND_BUS_ACK)
              & addr_hit;
    end

    // ======================================================================
    // Bus slave: one wait state, answer from flops
    always_comb begin
        next_bus_state = bus_state;
        next_pready    = 1'b0;
        next_pslverr   = 1'b0;
        next_prdata    = apb_rsp.prdata;
        case (bus_state)
            eind_pkg::EIND_BUS_WAIT: begin
                if (apb_req.psel && apb_req.penable) begin
                    next_bus_state = eind_pkg::EIND_BUS_ACK;
                    next_pready    = 1'b1;
                    next_pslverr   = ~addr_hit;
                    next_prdata    = apb_req.pwrite ? `EIND_ZERO : rd_value;
                end
            end
            default: begin
                next_bus_state = eind_pkg::EIND_BUS_WAIT;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state       <= eind_pkg::EIND_BUS_WAIT;
            apb_rsp.pready  <= 1'b0;
            apb_rsp.pslverr <= 1'b0;
            apb_rsp.prdata  <= `EIND_ZERO;
        end else begin
            bus_state       <= next_bus_state;
            apb_rsp.pready  <= next_pready;
            apb_rsp.pslverr <= next_pslverr;
            apb_rsp.prdata  <= next_prdata;
        end
    end

    // ======================================================================
    // Software registers
    always_comb begin
        next_detect_sel               = detect_sel;
        next_enable_mask              = enable_mask;
        next_port_function_select_bit = port_function_select_bit;
        clear_mask                    = '0;
        nmi_clear                     = 1'b0;
        if (wr_go) begin
            if (apb_req.paddr == `EIND_OFF_SEL) begin
                next_detect_sel = apb_req.pwdata[SEL_W-1:0];  // R1
            end else if (apb_req.paddr == `EIND_OFF_FCLR) begin
                clear_mask = ~apb_req.pwdata[NUM_PINS-1:0];  // R19
            end else if (apb_req.paddr == `EIND_OFF_ENA) begin
                next_enable_mask = apb_req.pwdata[NUM_PINS-1:0];
            end else if (apb_req.paddr == `EIND_OFF_NMI_CLR) begin
                nmi_clear = ~apb_req.pwdata[`EIND_NMI_BIT];  // R7
            end else if (apb_req.paddr == `EIND_OFF_PORTSEL) begin
                next_port_function_select_bit =
                    apb_req.pwdata[`EIND_PFS_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detect_sel               <= SEL_W'(`EIND_SEL_RST);
            enable_mask              <= NUM_PINS'(`EIND_ENA_RST);
            port_function_select_bit <= 1'b0;
        end else begin
            detect_sel               <= next_detect_sel;
            enable_mask              <= next_enable_mask;
            port_function_select_bit <= next_port_function_select_bit;
        end
    end

    // ======================================================================
    // Factor flags: set wins over clear
    always_comb begin
        next_factor_flags = (factor_flags & ~clear_mask) | pin_hit;  // R4 R10
        next_nmi_detected_flag =
            (nmi_detected_flag & ~nmi_clear) | nmi_hit;  // R5
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            factor_flags      <= '0;
            nmi_detected_flag <= 1'b0;
        end else begin
            factor_flags      <= next_factor_flags;
            nmi_detected_flag <= next_nmi_detected_flag;
        end
    end

    // ======================================================================
    // Request outputs
    always_comb begin
        next_ext_irq_req = next_factor_flags & next_enable_mask;  // R18
        next_nmi_req     = next_nmi_detected_flag;  // R13
        next_stop_wake   = stop_mode & ~nmi_int;  // R12
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_req <= '0;
            nmi_req     <= 1'b0;
            stop_wake   <= 1'b0;
        end else begin
            ext_irq_req <= next_ext_irq_req;
            nmi_req     <= next_nmi_req;
            stop_wake   <= next_stop_wake;
        end
    end

endmodule : eind_top

// *** design/eind_consts.svh ***
// Constants for the external interrupt and NMI detection block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef EIND_CONSTS_SVH
`define EIND_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses, one aligned word each)
`define EIND_OFF_SEL      8'h00
`define EIND_OFF_FLAGS    8'h04
`define EIND_OFF_FCLR     8'h08
`define EIND_OFF_ENA      8'h0C
`define EIND_OFF_NMI_STS  8'h10
`define EIND_OFF_NMI_CLR  8'h14
`define EIND_OFF_PORTSEL  8'h18

// ==========================================================================
// Field positions and reset values
`define EIND_NMI_BIT      0
`define EIND_PFS_BIT      0
`define EIND_SEL_RST      32'h0000_0000
`define EIND_ENA_RST      32'h0000_0000
`define EIND_ONES         32'hFFFF_FFFF
`define EIND_ZERO         32'h0000_0000
`define EIND_NMI_CLR_RD   32'h0000_0001

// ==========================================================================
// Detection selector codes, high bit first
`define EIND_SEL_LOW      2'h0
`define EIND_SEL_HIGH     2'h1
`define EIND_SEL_RISE     2'h2
`define EIND_SEL_FALL     2'h3

// ==========================================================================
// Timing
`define EIND_MIN_PULSE_T  3
`define EIND_SYNC_STAGES  2

`endif

// *** design/eind_pkg.sv ***
// Types for the external interrupt and NMI detection block.
// Assumes the constants header is on the include path.
`include "eind_consts.svh"

package eind_pkg;

    // ======================================================================
    // APB request and answer
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } eind_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } eind_apb_rsp_t;

    // ======================================================================
    // Bus slave phase
    typedef enum logic [0:0] {
        EIND_BUS_WAIT = 1'b0,
        EIND_BUS_ACK  = 1'b1
    } eind_bus_state_t;

endpackage : eind_pkg

// *** tb/eind_monitor.sv ***
// Checker for the detection block's ports.
// Assumes binding to eind_top; one clock domain.
`timescale 1ns/1ps
module eind_monitor #(
    parameter int NUM_PINS = 16
) (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire eind_pkg::eind_apb_req_t apb_req,
    input wire eind_pkg::eind_apb_rsp_t apb_rsp,
    input wire logic [NUM_PINS-1:0]     external_irq_pin,
    input wire logic                    nonmaskable_input_pin,
    input wire logic                    stop_mode,
    input wire logic [NUM_PINS-1:0]     ext_irq_req,
    input wire logic                    nmi_req,
    input wire logic                    stop_wake
);
    // ====================
    // Properties
    logic wr;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        apb_req.psel && apb_req.penable && !apb_rsp.pready;
    endsequence
    sequence s_recent_write;
        $past(wr) || $past(wr, 2);
    endsequence
    a_ready_after_access: assert property (s_access |=> apb_rsp.pready)
        else $error("no ready after access");
    a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error without ready");
    a_write_data_zero: assert property (apb_rsp.pready && apb_req.pwrite
        |-> apb_rsp.prdata == 32'h0000_0000) else $error("data on write");
    a_req_drop_write: assert property (
        |($past(ext_irq_req) & ~ext_irq_req) |-> s_recent_write)
        else $error("pin request dropped without write");
    a_nmi_drop_write: assert property (
        $fell(nmi_req) |-> s_recent_write)
        else $error("nmi request dropped without write");
    a_nmi_needs_low: assert property ($rose(nmi_req) |->
        !$past(nonmaskable_input_pin, 2) || !$past(nonmaskable_input_pin, 3)
        || !$past(nonmaskable_input_pin, 4)) else $error("nmi without low");
    a_wake_in_stop: assert property (stop_wake |-> $past(stop_mode))
        else $error("wake outside stop");
    a_wake_sets_nmi: assert property (stop_wake |-> ##[0:1] nmi_req)
        else $error("wake without nmi request");
endmodule : eind_monitor

bind eind_top eind_monitor #(.NUM_PINS(NUM_PINS)) u_mon (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .external_irq_pin(external_irq_pin), .stop_mode(stop_mode),
    .nonmaskable_input_pin(nonmaskable_input_pin), .nmi_req(nmi_req),
    .ext_irq_req(ext_irq_req), .stop_wake(stop_wake)
);

// *** tb/eind_pin_model.sv ***
// Pin model: external interrupt pins and NMI input.
// Assumes the bench sets levels and holds each for 3 pclk or more.
`timescale 1ns/1ps
module eind_pin_model (
    input  wire logic        pclk,
    input  wire logic [15:0] set_pins,
    input  wire logic        set_nmi,
    output      logic [15:0] pins,
    output      logic        nmi_pin
);
    // ====================
    // Pins change just after the edge
    initial begin
        pins = 16'hFFFF;
        nmi_pin = 1'b1;
    end
    always @(posedge pclk) begin
        pins <= set_pins;
        nmi_pin <= set_nmi;
    end
endmodule : eind_pin_model

// *** tb/tb.sv ***
// Bench for the detection block: APB tasks and scenario sequence.
// Assumes the design files and constants header are compiled first.
`timescale 1ns/1ps
`include "eind_consts.svh"
module tb;
    logic                    pclk;
    logic                    presetn;
    logic                    stop_mode;
    logic [15:0]             set_pins;
    logic                    set_nmi;
    logic [15:0]             pins;
    logic                    nmi_pin;
    logic [15:0]             ext_irq_req;
    logic                    nmi_req;
    logic                    stop_wake;
    eind_pkg::eind_apb_req_t req;
    eind_pkg::eind_apb_rsp_t rsp;
    logic [31:0]             q;
    logic                    e;
    int                      n_mismatch;
    int                      tests_run;

    always #12.5 pclk = ~pclk;

    eind_pin_model u_pins (.pclk(pclk), .set_pins(set_pins),
        .set_nmi(set_nmi), .pins(pins), .nmi_pin(nmi_pin));
    eind_top #(.NUM_PINS(16)) DUT (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .external_irq_pin(pins),
        .nonmaskable_input_pin(nmi_pin), .stop_mode(stop_mode),
        .ext_irq_req(ext_irq_req), .nmi_req(nmi_req), .stop_wake(stop_wake));

    // ====================
    // Tasks
    task print_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
        tests_run++;
        if (seen !== x) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, x, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (rsp.pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (rsp.pready !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, q, x);
    endtask : rd
    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc

    // ====================
    // Scenarios
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        stop_mode = 1'b0;
        set_pins = 16'hFFFF;
        set_nmi = 1'b1;
        req = '0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        cyc(4);
        rd("sel", `EIND_OFF_SEL, 32'h0000_0000);
        rd("ena", `EIND_OFF_ENA, 32'h0000_0000);
        rd("flags", `EIND_OFF_FLAGS, 32'h0000_0000);
        rd("fclr", `EIND_OFF_FCLR, 32'h0000_FFFF);
        wr(`EIND_OFF_NMI_STS, 32'hFFFF_FFFF);
        rd("nmi_sts", `EIND_OFF_NMI_STS, 32'h0000_0000);
        rd("nmi_clr", `EIND_OFF_NMI_CLR, 32'h0000_0001);
        rd("unmapped", 8'h1C, 32'h0000_0000);
        chk("slverr", {31'h0, e}, 32'h0000_0001);
        wr(`EIND_OFF_SEL, 32'hAAAA_AAAA);
        rd("sel_rw", `EIND_OFF_SEL, 32'hAAAA_AAAA);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            set_pins[0] <= (c == 0 || c == 3);
            cyc(6);
            wr(`EIND_OFF_SEL, {30'h0, c[1:0]});
            wr(`EIND_OFF_FCLR, 32'h0000_0000);
            rd("idle", `EIND_OFF_FLAGS, 32'h0000_0000);
            set_pins[0] <= ~set_pins[0];
            cyc(6);
            wr(`EIND_OFF_FCLR, 32'hFFFF_FFFF);
            rd("hit", `EIND_OFF_FLAGS, 32'h0000_0001);
            wr(`EIND_OFF_FCLR, 32'hFFFF_FFFE);
            rd("again", `EIND_OFF_FLAGS, (c < 2) ? 32'h0000_0001 : '0);
        end
        $display("test detection codes done");
        wr(`EIND_OFF_SEL, 32'h0000_0000);
        cyc(6);
        chk("req_off", {16'h0, ext_irq_req}, 32'h0000_0000);
        wr(`EIND_OFF_FLAGS, 32'h0000_0000);
        rd("held", `EIND_OFF_FLAGS, 32'h0000_0001);
        wr(`EIND_OFF_ENA, 32'h0000_0001);
        cyc(2);
        chk("req_on", {16'h0, ext_irq_req}, 32'h0000_0001);
        set_pins[0] <= 1'b1;
        cyc(6);
        wr(`EIND_OFF_FCLR, 32'h0000_0000);
        cyc(2);
        chk("req_clr", {16'h0, ext_irq_req}, 32'h0000_0000);
        $display("test enable done");
        set_nmi <= 1'b0;
        cyc(6);
        chk("nmi_req", {31'h0, nmi_req}, 32'h0000_0001);
        wr(`EIND_OFF_NMI_CLR, 32'hFFFF_FFFF);
        rd("nmi_keep", `EIND_OFF_NMI_STS, 32'h0000_0001);
        wr(`EIND_OFF_NMI_CLR, 32'h0000_0000);
        rd("nmi_gone", `EIND_OFF_NMI_STS, 32'h0000_0000);
        wr(`EIND_OFF_PORTSEL, 32'h0000_0001);
        wr(`EIND_OFF_NMI_CLR, 32'h0000_0000);
        set_nmi <= 1'b1;
        cyc(6);
        set_nmi <= 1'b0;
        cyc(6);
        rd("nmi_forced", `EIND_OFF_NMI_STS, 32'h0000_0000);
        wr(`EIND_OFF_PORTSEL, 32'h0000_0000);
        cyc(4);
        rd("nmi_remap", `EIND_OFF_NMI_STS, 32'h0000_0001);
        $display("test nmi done");
        set_nmi <= 1'b1;
        stop_mode <= 1'b1;
        cyc(6);
        wr(`EIND_OFF_NMI_CLR, 32'h0000_0000);
        chk("wake_idle", {31'h0, stop_wake}, 32'h0000_0000);
        set_nmi <= 1'b0;
        cyc(6);
        chk("wake", {31'h0, stop_wake}, 32'h0000_0001);
        set_nmi <= 1'b1;
        stop_mode <= 1'b0;
        cyc(6);
        $display("test stop wake done");
        print_verdict();
    end
endmodule : tb
